/* File: iwd_top.sv */
// Instruction word decoder with four-phase sequencer and register access
//
// Overview of operation
// - Take one 14-bit word, opcode plus operands
// - Byte class: file field addresses data memory
// - Destination bit clear sends result to W
// - Destination bit set writes addressed register
// - Register address is seven bits, 0x00-0x7F
// - Bit class: bit field picks one of eight
// - Bit class: file field addresses data memory
// - Literal class carries 8-bit constant, jump class 11-bit
// - Don't-care bits never change the decoded op code
// - One cycle; two if test true or PC changes (jump, return)
// - Second cycle is a no-operation flush
// - Instruction cycle lasts four clock periods
`include "iwd_params.svh"

module iwd_top (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic condTrue,
   output logic [1:0] cyclePhase,
   output logic cycleEnd,
   output logic execActive,
   output logic nopCycle,
   output iwd_pkg::iwd_class_t execClass,
   output logic [3:0] execOp,
   output logic [`IWD_FILE_W-1:0] execFileAddr,
   output logic execToW,
   output logic execToFile,
   output logic [`IWD_BSEL_W-1:0] execBitSel,
   output logic [`IWD_LIT8_W-1:0] execLit8,
   output logic [`IWD_LIT11_W-1:0] execLit11,
   output logic execChangesPc,
   output logic execIsTest
);

   // ==========================================================
   // Bus front end
   logic regWrEn;
   logic [`IWD_ADDR_W-1:0] regWrAddr;
   logic [31:0] regWrData;
   logic [`IWD_ADDR_W-1:0] regRdAddr;
   logic [31:0] regRdData;

   iwd_ahb_slave u_bus (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .regWrEn(regWrEn),
      .regWrAddr(regWrAddr),
      .regWrData(regWrData),
      .regRdAddr(regRdAddr),
      .regRdData(regRdData)
   );

   // ==========================================================
   // Software registers
   logic [`IWD_WORD_W-1:0] instr_q;
   logic runEnable_q;
   logic pending_q;
   logic pending_d;
   logic wrInstr;
   logic wrCtrl;

   assign wrInstr = regWrEn & (regWrAddr == `IWD_OFF_INSTR);
   assign wrCtrl = regWrEn & (regWrAddr == `IWD_OFF_CTRL);

   // Only the low 14 bits are kept; upper write bits are dropped
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         instr_q <= `IWD_INSTR_RST;
         runEnable_q <= `IWD_RUN_RST;
      end else if (clkEn) begin
         if (wrInstr) begin
            instr_q <= regWrData[`IWD_WORD_W-1:0];
         end
         if (wrCtrl) begin
            runEnable_q <= regWrData[0];
         end
      end
   end

   // ==========================================================
   // Decode of the waiting word
   iwd_pkg::iwd_class_t decClass;
   logic [3:0] decOp;
   logic [`IWD_FILE_W-1:0] decFile;
   logic decDest;
   logic [`IWD_BSEL_W-1:0] decBit;
   logic [`IWD_LIT8_W-1:0] decLit8;
   logic [`IWD_LIT11_W-1:0] decLit11;
   logic decChangesPc;
   logic decIsTest;

   iwd_field_decode u_dec (
      .instrWord(instr_q),
      .instrClass(decClass),
      .opCode(decOp),
      .fileAddr(decFile),
      .destFile(decDest),
      .bitSel(decBit),
      .lit8(decLit8),
      .lit11(decLit11),
      .changesPc(decChangesPc),
      .isTest(decIsTest)
   );

   // ==========================================================
   // Four-phase instruction cycle counter
   logic [1:0] phase_q;
   logic [1:0] phase_d;

   // Free running so cycle boundaries stay aligned to reset
   assign phase_d = phase_q + 2'h1;
   assign cycleEnd = clkEn & (phase_q == `IWD_PHASE_LAST);
   assign cyclePhase = phase_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         phase_q <= 2'h0;
      end else if (clkEn) begin
         phase_q <= phase_d;
      end
   end

   // ==========================================================
   // Sequencer
   iwd_pkg::iwd_state_t state_q;
   iwd_pkg::iwd_state_t state_d;
   logic twoCycle;
   logic canTake;
   logic take;
   logic lastTwo_q;

   // Second cycle needed for a taken test or a PC change (jump, return)
   assign twoCycle = execChangesPc | (execIsTest & condTrue);

   // A new word is accepted only on a cycle boundary
   assign canTake = (state_q != iwd_pkg::IWD_ST_EXEC) | ~twoCycle;
   assign take = cycleEnd & pending_q & runEnable_q & canTake;

   // Set wins: a write in the take cycle stays pending
   assign pending_d = wrInstr | (pending_q & ~take);

   always_comb begin
      state_d = state_q;
      if (cycleEnd) begin
         unique case (state_q)
            iwd_pkg::IWD_ST_IDLE: begin
               state_d = take ? iwd_pkg::IWD_ST_EXEC : iwd_pkg::IWD_ST_IDLE;
            end
            iwd_pkg::IWD_ST_EXEC: begin
               if (twoCycle) begin
                  state_d = iwd_pkg::IWD_ST_FLUSH;
               end else if (take) begin
                  state_d = iwd_pkg::IWD_ST_EXEC;
               end else begin
                  state_d = iwd_pkg::IWD_ST_IDLE;
               end
            end
            iwd_pkg::IWD_ST_FLUSH: begin
               state_d = take ? iwd_pkg::IWD_ST_EXEC : iwd_pkg::IWD_ST_IDLE;
            end
            default: begin
               state_d = iwd_pkg::IWD_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= iwd_pkg::IWD_ST_IDLE;
         pending_q <= 1'b0;
         lastTwo_q <= 1'b0;
      end else if (clkEn) begin
         state_q <= state_d;
         pending_q <= pending_d;
         if (cycleEnd && state_q == iwd_pkg::IWD_ST_EXEC) begin
            lastTwo_q <= twoCycle;
         end
      end
   end

   // Flush cycle drives neither write strobe; the held decoded fields stay on their outputs
   assign execActive = (state_q == iwd_pkg::IWD_ST_EXEC);
   assign nopCycle = (state_q == iwd_pkg::IWD_ST_FLUSH);

   // ==========================================================
   // Decoded controls held for the whole execute cycle
   iwd_pkg::iwd_class_t cls_q;
   logic [3:0] op_q;
   logic [`IWD_FILE_W-1:0] file_q;
   logic dest_q;
   logic [`IWD_BSEL_W-1:0] bit_q;
   logic [`IWD_LIT8_W-1:0] lit8_q;
   logic [`IWD_LIT11_W-1:0] lit11_q;
   logic pcChg_q;
   logic test_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cls_q <= iwd_pkg::IWD_BYTE;
         op_q <= 4'h0;
         file_q <= 7'h00;
         dest_q <= 1'b0;
         bit_q <= 3'h0;
         lit8_q <= 8'h00;
         lit11_q <= 11'h000;
         pcChg_q <= 1'b0;
         test_q <= 1'b0;
      end else if (clkEn && take) begin
         cls_q <= decClass;
         op_q <= decOp;
         file_q <= decFile;
         dest_q <= decDest;
         bit_q <= decBit;
         lit8_q <= decLit8;
         lit11_q <= decLit11;
         pcChg_q <= decChangesPc;
         test_q <= decIsTest;
      end
   end

   // Write targets gated by class and by the execute state
   assign execClass = cls_q;
   assign execOp = op_q;
   assign execFileAddr = file_q;
   assign execToW = execActive & (cls_q == iwd_pkg::IWD_BYTE) &
                    ~dest_q;
   assign execToFile = execActive & (cls_q == iwd_pkg::IWD_BYTE) &
                       dest_q;
   assign execBitSel = bit_q;
   assign execLit8 = lit8_q;
   assign execLit11 = lit11_q;
   assign execChangesPc = pcChg_q;
   assign execIsTest = test_q;

   // ==========================================================
   // Read-back mux; unmapped offsets read as zero
   logic [31:0] rdInstr;
   logic [31:0] rdCtrl;
   logic [31:0] rdStatus;
   logic [31:0] rdFields;

   assign rdInstr = {18'h00000, instr_q};
   assign rdCtrl = {31'h00000000, runEnable_q};
   assign rdStatus = {20'h00000, test_q, pcChg_q, lastTwo_q, 1'b0,
                      cls_q, state_q, phase_q, 1'b0, pending_q};
   assign rdFields = {5'h00, lit11_q, op_q, 1'b0, bit_q,
                      dest_q, file_q};
   assign regRdData = (regRdAddr == `IWD_OFF_INSTR) ? rdInstr :
                      (regRdAddr == `IWD_OFF_CTRL) ? rdCtrl :
                      (regRdAddr == `IWD_OFF_STATUS) ? rdStatus :
                      (regRdAddr == `IWD_OFF_FIELDS) ? rdFields :
                      32'h00000000;

endmodule

/* File: iwd_params.svh */
// Constants for the instruction word decoder: fields, codes, map, timing
`ifndef IWD_PARAMS_SVH
`define IWD_PARAMS_SVH

// ==========================================================
// Instruction word layout
`define IWD_WORD_W 14
`define IWD_CLASS_HI 13
`define IWD_CLASS_LO 12
`define IWD_OP_HI 11
`define IWD_OP_LO 8
`define IWD_DEST_POS 7
`define IWD_FILE_HI 6
`define IWD_FILE_W 7
`define IWD_BSEL_HI 9
`define IWD_BSEL_LO 7
`define IWD_BSEL_W 3
`define IWD_LIT8_W 8
`define IWD_LIT11_HI 10
`define IWD_LIT11_W 11
`define IWD_TEST_POS 11

// ==========================================================
// Class and operation codes
`define IWD_CLS_BYTE 2'h0
`define IWD_CLS_BIT 2'h1
`define IWD_CLS_JUMP 2'h2
`define IWD_CLS_LIT 2'h3
`define IWD_OP_CTL 4'h0
`define IWD_OP_DECSKIP 4'hB
`define IWD_OP_INCSKIP 4'hF
`define IWD_OP_LITRET 4'h4
`define IWD_CTL_RETURN 7'h08
`define IWD_CTL_RETINT 7'h09

// ==========================================================
// Register map (byte addresses) and reset values
`define IWD_ADDR_W 8
`define IWD_OFF_INSTR 8'h00
`define IWD_OFF_CTRL 8'h04
`define IWD_OFF_STATUS 8'h08
`define IWD_OFF_FIELDS 8'h0C
`define IWD_INSTR_RST 14'h0000
`define IWD_RUN_RST 1'h1
`define IWD_HSIZE_WORD 3'h2

// ==========================================================
// Sequencing: oscillator periods per instruction cycle
`define IWD_PHASES 4
`define IWD_PHASE_LAST 2'h3

`endif

/* File: iwd_pkg.sv */
// Types shared by the instruction word decoder modules
`include "iwd_params.svh"

package iwd_pkg;

   // ==========================================================
   // Instruction classes
   typedef enum logic [1:0] {
      IWD_BYTE = `IWD_CLS_BYTE,
      IWD_BIT = `IWD_CLS_BIT,
      IWD_JUMP = `IWD_CLS_JUMP,
      IWD_LIT = `IWD_CLS_LIT
   } iwd_class_t;

   // ==========================================================
   // Sequencer states, Gray along idle, execute, flush
   typedef enum logic [1:0] {
      IWD_ST_IDLE = 2'b00,
      IWD_ST_EXEC = 2'b01,
      IWD_ST_FLUSH = 2'b11
   } iwd_state_t;

endpackage

/* File: iwd_field_decode.sv */
// Combinational split of one instruction word into class and operands
`include "iwd_params.svh"

module iwd_field_decode (
   input wire logic [`IWD_WORD_W-1:0] instrWord,
   output iwd_pkg::iwd_class_t instrClass,
   output logic [3:0] opCode,
   output logic [`IWD_FILE_W-1:0] fileAddr,
   output logic destFile,
   output logic [`IWD_BSEL_W-1:0] bitSel,
   output logic [`IWD_LIT8_W-1:0] lit8,
   output logic [`IWD_LIT11_W-1:0] lit11,
   output logic changesPc,
   output logic isTest
);

   // ==========================================================
   // Raw fields
   logic [3:0] opRaw;
   logic isByte;
   logic isBit;
   logic isJump;
   logic isLit;

   assign instrClass = iwd_pkg::iwd_class_t'(
      instrWord[`IWD_CLASS_HI:`IWD_CLASS_LO]);
   assign opRaw = instrWord[`IWD_OP_HI:`IWD_OP_LO];
   assign isByte = (instrClass == iwd_pkg::IWD_BYTE);
   assign isBit = (instrClass == iwd_pkg::IWD_BIT);
   assign isJump = (instrClass == iwd_pkg::IWD_JUMP);
   assign isLit = (instrClass == iwd_pkg::IWD_LIT);

   // Operand fields; both register classes share the address bits
   assign fileAddr = instrWord[`IWD_FILE_HI:0];
   assign destFile = isByte & instrWord[`IWD_DEST_POS];
   assign bitSel = instrWord[`IWD_BSEL_HI:`IWD_BSEL_LO];
   assign lit8 = instrWord[`IWD_LIT8_W-1:0];
   assign lit11 = instrWord[`IWD_LIT11_HI:0];

   // Operation code with don't-care positions forced to zero
   assign opCode = isByte ? opRaw :
                   isJump ? {opRaw[3], 3'h0} :
                   isBit ? {opRaw[3:2], 2'h0} :
                   opRaw[3] ? {opRaw[3:1], 1'h0} :
                   {opRaw[3:2], 2'h0};

   // Conditional tests and program counter changes
   assign isTest = (isByte & ((opRaw == `IWD_OP_DECSKIP) |
                              (opRaw == `IWD_OP_INCSKIP))) |
                   (isBit & instrWord[`IWD_TEST_POS]);
   assign changesPc = isJump |
                      (isLit & (opCode == `IWD_OP_LITRET)) |
                      (isByte & (opRaw == `IWD_OP_CTL) &
                       ~instrWord[`IWD_DEST_POS] &
                       ((fileAddr == `IWD_CTL_RETURN) |
                        (fileAddr == `IWD_CTL_RETINT)));

endmodule

/* File: iwd_ahb_slave.sv */
// AHB-Lite slave front end: zero wait states while clkEn is high, registered read data
`include "iwd_params.svh"

module iwd_ahb_slave (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic regWrEn,
   output logic [`IWD_ADDR_W-1:0] regWrAddr,
   output logic [31:0] regWrData,
   output logic [`IWD_ADDR_W-1:0] regRdAddr,
   input wire logic [31:0] regRdData
);

   // ==========================================================
   // Address phase qualification
   logic accept;
   logic wordOk;
   logic wrPend_q;
   logic [`IWD_ADDR_W-1:0] wrAddr_q;
   logic [31:0] hrdata_q;

   assign wordOk = (hsize == `IWD_HSIZE_WORD);
   assign accept = hsel & htrans[1] & hready & clkEn;
   assign regRdAddr = haddr[`IWD_ADDR_W-1:0];

   // Stall the bus while the core is frozen
   assign hreadyout = clkEn;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // Write lands in the data phase, once hwdata is valid
   assign regWrEn = wrPend_q & clkEn;
   assign regWrAddr = wrAddr_q;
   assign regWrData = hwdata;

   // Capture address phase; read data sampled at the same edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
         hrdata_q <= 32'h00000000;
      end else if (clkEn && hready) begin
         wrPend_q <= accept & hwrite & wordOk;
         wrAddr_q <= regRdAddr;
         if (accept && !hwrite) begin
            hrdata_q <= wordOk ? regRdData : 32'h00000000;
         end
      end
   end

endmodule

/* File: iwd_top_sva.sv */
// Concurrent checks on the decoder's sequencing and decode outputs
`include "iwd_params.svh"

module iwd_top_sva (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic condTrue,
   input wire logic [1:0] cyclePhase,
   input wire logic cycleEnd,
   input wire logic execActive,
   input wire logic nopCycle,
   input wire iwd_pkg::iwd_class_t execClass,
   input wire logic [`IWD_LIT11_W-1:0] execLit11,
   input wire logic execToW,
   input wire logic execToFile,
   input wire logic execChangesPc,
   input wire logic execIsTest
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Everything here lives in the one core clock domain
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // ==========================================================
   // Bus front end and phase counter
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not OKAY");
   a_ready_en: assert property (hreadyout == clkEn)
      else $error("hreadyout does not follow clkEn");
   a_phase_step: assert property (
      clkEn |=> cyclePhase == $past(cyclePhase) + 2'h1)
      else $error("phase did not advance by one");
   a_end_pulse: assert property (
      cycleEnd == (clkEn && cyclePhase == 2'h3))
      else $error("cycleEnd not at last phase");
   a_exec_start: assert property (
      $rose(execActive) |-> cyclePhase == 2'h0)
      else $error("execute began off a cycle boundary");

   // ==========================================================
   // One or two instruction cycles
   a_pc_flush: assert property (
      cycleEnd && execActive && execChangesPc |=> nopCycle)
      else $error("PC change not followed by flush");
   a_test_flush: assert property (
      cycleEnd && execActive && execIsTest && condTrue |=> nopCycle)
      else $error("true test not followed by flush");
   a_plain_single: assert property (
      cycleEnd && execActive && !execChangesPc
      && !(execIsTest && condTrue) |=> !nopCycle)
      else $error("plain instruction took a second cycle");
   a_flush_once: assert property (
      cycleEnd && nopCycle |=> !nopCycle)
      else $error("flush lasted beyond one cycle");
   a_flush_quiet: assert property (
      nopCycle |-> !execToW && !execToFile)
      else $error("write strobe during flush");

   // ==========================================================
   // Destination select and held operands
   a_dest_excl: assert property (
      execActive && execClass == iwd_pkg::IWD_BYTE |-> execToW ^ execToFile)
      else $error("byte op needs exactly one destination");
   a_dest_other: assert property (
      !(execActive && execClass == iwd_pkg::IWD_BYTE)
      |-> !execToW && !execToFile)
      else $error("destination strobe outside byte execute");
   a_lit_hold: assert property (
      cyclePhase != 2'h0 |-> $stable(execLit11))
      else $error("literal changed inside a cycle");
endmodule

bind iwd_top iwd_top_sva chk_i (
   .core_clk(core_clk), .nrst(nrst), .clkEn(clkEn),
   .hreadyout(hreadyout), .hresp(hresp), .condTrue(condTrue),
   .cyclePhase(cyclePhase), .cycleEnd(cycleEnd),
   .execActive(execActive), .nopCycle(nopCycle),
   .execClass(execClass), .execLit11(execLit11),
   .execToW(execToW), .execToFile(execToFile),
   .execChangesPc(execChangesPc), .execIsTest(execIsTest)
);

/* File: iwd_prog_mem.sv */
// Program memory model: a small table of instruction words
`include "iwd_params.svh"

module iwd_prog_mem (
   input wire logic [2:0] progAddr,
   output logic [`IWD_WORD_W-1:0] progWord
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Whole 14-bit words, one per location
   always_comb begin
      case (progAddr)
         3'h0: progWord = 14'h07FF; // Byte op, d=1, f=7F
         3'h1: progWord = 14'h077F; // Byte op, d=0, f=7F
         3'h2: progWord = 14'h12AA; // Bit op, b=5, f=2A
         3'h3: progWord = 14'h30A5; // 8-bit literal
         3'h4: progWord = 14'h33A5; // Same, loose bits set
         3'h5: progWord = 14'h25A3; // 11-bit jump
         3'h6: progWord = 14'h0B20; // Skip test, d=0, f=20
         default: progWord = 14'h0000;
      endcase
   end
endmodule

/* File: tb_top.sv */
// Self-checking bench: registers, decode fields and cycle timing
`include "iwd_params.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk, nrst, clkEn, hsel, hwrite, condTrue;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, cyclePhase, p;
   logic [2:0] hsize, progAddr;
   logic hreadyout, hresp, cycleEnd, execActive, nopCycle;
   logic execToW, execToFile, execChangesPc, execIsTest, seenW, seenF;
   iwd_pkg::iwd_class_t execClass;
   logic [3:0] execOp;
   logic [6:0] execFileAddr;
   logic [2:0] execBitSel;
   logic [7:0] execLit8;
   logic [10:0] execLit11;
   logic [13:0] progWord;
   int n_fail = 0;
   int n_tests = 0;

   // ==========================================================
   // Device, partner and clock
   iwd_top dut (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .condTrue(condTrue), .cyclePhase(cyclePhase), .cycleEnd(cycleEnd),
      .execActive(execActive), .nopCycle(nopCycle), .execClass(execClass),
      .execOp(execOp), .execFileAddr(execFileAddr), .execToW(execToW),
      .execToFile(execToFile), .execBitSel(execBitSel),
      .execLit8(execLit8), .execLit11(execLit11),
      .execChangesPc(execChangesPc), .execIsTest(execIsTest));
   iwd_prog_mem pmem (.progAddr(progAddr), .progWord(progWord));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ==========================================================
   // Reporting
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ==========================================================
   // Single AHB-Lite transfer; waits on hready, never on a count
   task automatic ahb(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rdv);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= `IWD_HSIZE_WORD;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask

   // Issue one word from program memory and time its cycles
   task automatic run(input logic [2:0] idx, input logic c,
         input logic fl);
      int n;
      int k;
      progAddr = idx;
      #1;
      @(posedge core_clk);
      condTrue <= c;
      while (execActive === 1'b1 || nopCycle === 1'b1)
         @(posedge core_clk);
      ahb(1'b1, `IWD_OFF_INSTR, {18'h00000, progWord}, rd);
      k = 0;
      do begin
         @(posedge core_clk);
         #1;
         k++;
      end while (execActive !== 1'b1 && k < 20);
      seenW = execToW;
      seenF = execToFile;
      n = 0;
      while (execActive === 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("exec length", 32'h4, n);
      chk("flush flag", {31'h0, fl}, {31'h0, nopCycle});
      n = 0;
      while (nopCycle === 1'b1 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("flush length", fl ? 32'h4 : 32'h0, n);
   endtask

   // ==========================================================
   // Hang guard, well past the few hundred cycles the tests take
   initial begin
      #100000;
      n_fail++;
      wrap_up;
   end

   // ==========================================================
   // Main sequence
   initial begin
      nrst = 1'b0;
      clkEn = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      condTrue = 1'b0;
      progAddr = 3'h0;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      ahb(1'b0, `IWD_OFF_CTRL, 32'h0, rd);
      chk("CTRL reset", 32'h1, rd);
      ahb(1'b0, `IWD_OFF_INSTR, 32'h0, rd);
      chk("INSTR reset", 32'h0, rd);
      ahb(1'b1, 8'h10, 32'hFFFFFFFF, rd);
      ahb(1'b0, 8'h10, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      run(3'h0, 1'b0, 1'b0);
      chk("to file", 32'h2, {seenF, seenW});
      chk("file addr", 32'h7F, execFileAddr);
      chk("op", 32'h7, execOp);
      run(3'h1, 1'b0, 1'b0);
      chk("to W", 32'h1, {seenF, seenW});
      run(3'h2, 1'b0, 1'b0);
      chk("class bit", 32'h1, execClass);
      chk("bit sel", 32'h5, execBitSel);
      chk("bit file", 32'h2A, execFileAddr);
      run(3'h3, 1'b0, 1'b0);
      chk("lit8", 32'hA5, execLit8);
      run(3'h4, 1'b0, 1'b0);
      chk("lit8 loose", 32'hA5, execLit8);
      chk("class loose", 32'h3, execClass);
      chk("op loose", 32'h0, execOp);
      run(3'h5, 1'b0, 1'b1);
      chk("lit11", 32'h5A3, execLit11);
      chk("jump pc", 32'h1, execChangesPc);
      // Held jump fields read back: lit11, op, bit, dest, file
      ahb(1'b0, `IWD_OFF_FIELDS, 32'h0, rd);
      chk("fields", 32'h05A30323, rd);
      run(3'h6, 1'b1, 1'b1);
      run(3'h6, 1'b0, 1'b0);
      chk("is test", 32'h1, execIsTest);
      // Freeze with clkEn low: phase and bus must both stall
      @(posedge core_clk);
      clkEn <= 1'b0;
      #1;
      p = cyclePhase;
      repeat (3) @(posedge core_clk);
      #1;
      chk("frozen phase", p, cyclePhase);
      chk("stall ready", 32'h0, hreadyout);
      @(posedge core_clk);
      clkEn <= 1'b1;
      run(3'h0, 1'b0, 1'b0);
      wrap_up;
   end
endmodule
